// *** src/simd_dual_element_data_move.sv ***
`timescale 1ns/1ps

module simd_dual_element_data_move (
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 reset,
  // Instruction from the sequencer
  input  wire logic                                 instr_valid,
  input  wire dual_move_pkg::op_e                   instr_op,
  input  wire logic                                 cond_first,
  input  wire logic                                 cond_second,
  input  wire logic                                 is_swap,
  input  wire logic                                 mem_read,
  input  wire logic                                 mem_enable,
  input  wire logic                                 pre_modify,
  input  wire logic                                 use_imm_modify,
  input  wire logic                                 long_word_option,
  input  wire logic                                 short_word_access,
  input  wire logic                                 split_operand,
  input  wire logic [dual_move_pkg::IMM_W-1:0]      imm_field,
  input  wire logic [dual_move_pkg::REG_SEL_W-1:0]  index_sel,
  input  wire logic [dual_move_pkg::REG_SEL_W-1:0]  modify_sel,
  input  wire logic [dual_move_pkg::REG_SEL_W-1:0]  src_sel,
  input  wire logic [dual_move_pkg::REG_SEL_W-1:0]  dst_sel,
  input  wire logic [dual_move_pkg::MODE_W-1:0]     primary_mode_control_word,
  // Memory read data
  input  wire logic [dual_move_pkg::DATA_W-1:0]     first_rd_data,
  input  wire logic [dual_move_pkg::DATA_W-1:0]     second_rd_data,
  // Compute results from each element
  input  wire logic [dual_move_pkg::DATA_W-1:0]     first_comp_result,
  input  wire logic [dual_move_pkg::DATA_W-1:0]     second_comp_result,
  input  wire logic                                 comp_present,
  // Status to the sequencer
  output      logic                                 busy,
  // Memory request of each element
  output      logic                                 first_mem_req,
  output      logic                                 second_mem_req,
  output      logic                                 mem_we,
  output      logic                                 mem_long,
  output      logic                                 mem_short,
  output      logic [dual_move_pkg::ADDR_W-1:0]     first_addr,
  output      logic [dual_move_pkg::ADDR_W-1:0]     second_addr,
  output      logic [dual_move_pkg::DATA_W-1:0]     first_wr_data,
  output      logic [dual_move_pkg::DATA_W-1:0]     second_wr_data,
  // Shifter operand and compute strobes
  output      logic                                 first_comp_en,
  output      logic                                 second_comp_en,
  output      logic [dual_move_pkg::IMM_W-1:0]      shift_operand,
  output      logic                                 shift_split,
  // Register file observation
  output      logic [dual_move_pkg::DATA_W-1:0]     first_reg_view,
  output      logic [dual_move_pkg::DATA_W-1:0]     second_reg_view,
  output      logic [dual_move_pkg::ADDR_W-1:0]     index_view
);

  localparam int unsigned DW = dual_move_pkg::DATA_W;
  localparam int unsigned AW = dual_move_pkg::ADDR_W;
  localparam int unsigned NR = dual_move_pkg::NUM_DREG;

  // Register files of both elements and the address generator's registers.
  logic [DW-1:0] first_file_q  [NR];
  logic [DW-1:0] first_file_d  [NR];
  logic [DW-1:0] second_file_q [NR];
  logic [DW-1:0] second_file_d [NR];
  logic [AW-1:0] index_q  [dual_move_pkg::NUM_IREG];
  logic [AW-1:0] index_d  [dual_move_pkg::NUM_IREG];
  logic [AW-1:0] modify_q [dual_move_pkg::NUM_IREG];

  dual_move_pkg::state_e state_q;
  dual_move_pkg::state_e state_d;

  logic                busy_q, busy_d;
  logic                first_req_q, first_req_d;
  logic                second_req_q, second_req_d;
  logic                we_q, we_d;
  logic                long_q, long_d;
  logic                short_q, short_d;
  logic [AW-1:0]       first_addr_q, first_addr_d;
  logic [AW-1:0]       second_addr_q, second_addr_d;
  logic [DW-1:0]       first_wd_q, first_wd_d;
  logic [DW-1:0]       second_wd_q, second_wd_d;
  logic                first_comp_q, first_comp_d;
  logic                second_comp_q, second_comp_d;
  logic [dual_move_pkg::IMM_W-1:0] shift_q, shift_d;
  logic                split_q, split_d;
  logic [AW-1:0]       index_view_q, index_view_d;
  logic [DW-1:0]       first_view_q, first_view_d, second_view_q, second_view_d;

  // Latched fields of the instruction in flight.
  logic                lat_read_q, lat_read_d;
  logic                lat_bcast_q, lat_bcast_d;
  logic                lat_run_first_q, lat_run_first_d;
  logic                lat_run_second_q, lat_run_second_d;
  logic [dual_move_pkg::REG_SEL_W-1:0] lat_dst_q, lat_dst_d;

  logic                dual_mode;
  logic                bcast_hit;
  logic                run_first;
  logic                run_second;
  logic [AW-1:0]       modify_val;
  logic [AW-1:0]       gen_first;
  logic [AW-1:0]       gen_second;
  logic [AW-1:0]       gen_index_next;
  dual_move_pkg::width_e width;

  function automatic logic is_broadcast(input logic [dual_move_pkg::REG_SEL_W-1:0] idx,
                                        input logic [dual_move_pkg::MODE_W-1:0]    mode);
    is_broadcast = (idx == dual_move_pkg::BCAST_IDX_FIRST
                    && mode[dual_move_pkg::MODE_BIT_BCAST1])
                || (idx == dual_move_pkg::BCAST_IDX_SECOND
                    && mode[dual_move_pkg::MODE_BIT_BCAST9]);
  endfunction

  assign dual_mode = primary_mode_control_word[dual_move_pkg::MODE_BIT_DUAL];
  // Broadcast only applies to reads; writes keep the usual offset.
  assign bcast_hit = dual_mode && mem_read && is_broadcast(index_sel, primary_mode_control_word);
  assign run_first  = cond_first;
  assign run_second = dual_mode && cond_second;
  assign modify_val = use_imm_modify ? {{(AW-dual_move_pkg::IMM_W){imm_field[dual_move_pkg::IMM_W-1]}},
                                        imm_field}
                                     : modify_q[modify_sel];

  always_comb begin
    if (long_word_option) begin
      width = dual_move_pkg::WIDTH_LONG;
    end else if (short_word_access) begin
      width = dual_move_pkg::WIDTH_SHORT;
    end else begin
      width = dual_move_pkg::WIDTH_NORMAL;
    end
  end

  element_addr_gen element_addr_gen_inst (
    .index_val  (index_q[index_sel]),
    .modify_val (modify_val),
    .pre_modify (pre_modify && instr_op == dual_move_pkg::OP_IDX_MOVE),
    .broadcast  (bcast_hit),
    .width      (width),
    .first_addr (gen_first),
    .second_addr(gen_second),
    .index_next (gen_index_next)
  );

  always_comb begin
    state_d          = state_q;
    busy_d           = busy_q;
    first_req_d      = 1'b0;
    second_req_d     = 1'b0;
    we_d             = we_q;
    long_d           = long_q;
    short_d          = short_q;
    first_addr_d     = first_addr_q;
    second_addr_d    = second_addr_q;
    first_wd_d       = first_wd_q;
    second_wd_d      = second_wd_q;
    first_comp_d     = 1'b0;
    second_comp_d    = 1'b0;
    shift_d          = shift_q;
    split_d          = split_q;
    index_view_d     = index_view_q;
    lat_read_d       = lat_read_q;
    lat_bcast_d      = lat_bcast_q;
    lat_run_first_d  = lat_run_first_q;
    lat_run_second_d = lat_run_second_q;
    lat_dst_d        = lat_dst_q;
    first_file_d     = first_file_q;
    second_file_d    = second_file_q;
    index_d          = index_q;
    unique case (state_q)
      dual_move_pkg::ST_IDLE: begin
        busy_d = 1'b0;
        if (instr_valid) begin
          lat_dst_d = dst_sel;
          unique case (instr_op)
            dual_move_pkg::OP_IDX_MOVE,
            dual_move_pkg::OP_SHIFT: begin
              if (instr_op == dual_move_pkg::OP_SHIFT) begin
                shift_d = imm_field;
                split_d = split_operand;
              end
              first_comp_d  = run_first && (comp_present || instr_op == dual_move_pkg::OP_SHIFT);
              second_comp_d = run_second
                              && (comp_present || instr_op == dual_move_pkg::OP_SHIFT);
              if (mem_enable && (run_first || run_second)) begin
                busy_d        = 1'b1;
                state_d       = dual_move_pkg::ST_ACCESS;
                first_req_d   = run_first;
                second_req_d  = run_second;
                we_d          = !mem_read;
                long_d        = width == dual_move_pkg::WIDTH_LONG;
                short_d       = width == dual_move_pkg::WIDTH_SHORT;
                first_addr_d  = gen_first;
                second_addr_d = gen_second;
                first_wd_d    = first_file_q[src_sel];
                second_wd_d   = second_file_q[src_sel];
                lat_read_d    = mem_read;
                lat_bcast_d   = bcast_hit;
                lat_run_first_d  = run_first;
                lat_run_second_d = run_second;
                // Index update is done once when either element runs, except for pre-modify index moves; it is shared state.
                if (!pre_modify || instr_op == dual_move_pkg::OP_SHIFT) begin
                  index_d[index_sel] = gen_index_next;
                  index_view_d = gen_index_next;
                end
              end
            end
            dual_move_pkg::OP_REG_MOVE: begin
              first_comp_d  = run_first && comp_present;
              second_comp_d = run_second && comp_present;
              if (is_swap) begin
                if (cond_first) begin
                  first_file_d[dst_sel]  = second_file_q[src_sel];
                  second_file_d[src_sel] = first_file_q[dst_sel];
                end
              end else if (!dual_mode) begin
                if (run_first) begin
                  first_file_d[dst_sel] = first_file_q[src_sel];
                end
              end else if (cond_first && cond_second) begin
                first_file_d[dst_sel]  = first_file_q[src_sel];
                second_file_d[dst_sel] = second_file_q[src_sel];
              end
            end
            dual_move_pkg::OP_NONE: busy_d = 1'b0;
          endcase
        end
      end
      dual_move_pkg::ST_ACCESS: begin
        state_d = dual_move_pkg::ST_WRITE;
      end
      dual_move_pkg::ST_WRITE: begin
        if (lat_read_q) begin
          if (lat_run_first_q) begin
            first_file_d[lat_dst_q] = first_rd_data;
          end
          if (lat_run_second_q) begin
            // Broadcast feeds the complementary register from the first element's word.
            second_file_d[lat_dst_q] = lat_bcast_q ? first_rd_data : second_rd_data;
          end
        end
        busy_d  = 1'b0;
        state_d = dual_move_pkg::ST_IDLE;
      end
      default: begin
        state_d = dual_move_pkg::ST_IDLE;
      end
    endcase
    // Compute results land in the destination register of each enabled element.
    if (first_comp_q) begin
      first_file_d[lat_dst_q] = first_comp_result;
    end
    if (second_comp_q) begin
      second_file_d[lat_dst_q] = second_comp_result;
    end
    first_view_d  = first_file_d[lat_dst_d];
    second_view_d = second_file_d[lat_dst_d];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q          <= dual_move_pkg::ST_IDLE;
      busy_q           <= 1'b0;
      first_req_q      <= 1'b0;
      second_req_q     <= 1'b0;
      we_q             <= 1'b0;
      long_q           <= 1'b0;
      short_q          <= 1'b0;
      first_addr_q     <= '0;
      second_addr_q    <= '0;
      first_wd_q       <= '0;
      second_wd_q      <= '0;
      first_comp_q     <= 1'b0;
      second_comp_q    <= 1'b0;
      shift_q          <= '0;
      split_q          <= 1'b0;
      index_view_q     <= '0;
      lat_read_q       <= 1'b0;
      lat_bcast_q      <= 1'b0;
      lat_run_first_q  <= 1'b0;
      lat_run_second_q <= 1'b0;
      lat_dst_q        <= '0;
      first_view_q     <= '0;
      second_view_q    <= '0;
    end else begin
      state_q          <= state_d;
      busy_q           <= busy_d;
      first_req_q      <= first_req_d;
      second_req_q     <= second_req_d;
      we_q             <= we_d;
      long_q           <= long_d;
      short_q          <= short_d;
      first_addr_q     <= first_addr_d;
      second_addr_q    <= second_addr_d;
      first_wd_q       <= first_wd_d;
      second_wd_q      <= second_wd_d;
      first_comp_q     <= first_comp_d;
      second_comp_q    <= second_comp_d;
      shift_q          <= shift_d;
      split_q          <= split_d;
      index_view_q     <= index_view_d;
      lat_read_q       <= lat_read_d;
      lat_bcast_q      <= lat_bcast_d;
      lat_run_first_q  <= lat_run_first_d;
      lat_run_second_q <= lat_run_second_d;
      lat_dst_q        <= lat_dst_d;
      first_view_q     <= first_view_d;
      second_view_q    <= second_view_d;
    end
  end

  // Register arrays are reset to zero; modifier registers are fixed at zero here.
  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_files
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          first_file_q[g]  <= '0;
          second_file_q[g] <= '0;
          index_q[g]       <= '0;
          modify_q[g]      <= '0;
        end else begin
          first_file_q[g]  <= first_file_d[g];
          second_file_q[g] <= second_file_d[g];
          index_q[g]       <= index_d[g];
        end
      end
    end
  endgenerate

  assign busy            = busy_q;
  assign first_mem_req   = first_req_q;
  assign second_mem_req  = second_req_q;
  assign mem_we          = we_q;
  assign mem_long        = long_q;
  assign mem_short       = short_q;
  assign first_addr      = first_addr_q;
  assign second_addr     = second_addr_q;
  assign first_wr_data   = first_wd_q;
  assign second_wr_data  = second_wd_q;
  assign first_comp_en   = first_comp_q;
  assign second_comp_en  = second_comp_q;
  assign shift_operand   = shift_q;
  assign shift_split     = split_q;
  assign first_reg_view  = first_view_q;
  assign second_reg_view = second_view_q;
  assign index_view      = index_view_q;

endmodule

// *** common/dual_move_pkg.sv ***
package dual_move_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned IMM_W  = 8;
  localparam int unsigned NUM_DREG = 16;
  localparam int unsigned REG_SEL_W = 4;
  localparam int unsigned NUM_IREG = 16;

  // Offset of the second element's address for each access width and for broadcast reads.
  localparam logic [ADDR_W-1:0] OFFSET_NORMAL = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] OFFSET_SHORT  = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] OFFSET_NONE   = 32'h0000_0000;

  // Index registers that carry a broadcast-read bit.
  localparam logic [REG_SEL_W-1:0] BCAST_IDX_FIRST  = 4'h1;
  localparam logic [REG_SEL_W-1:0] BCAST_IDX_SECOND = 4'h9;

  // Bit positions inside the primary mode control word.
  localparam int unsigned MODE_W           = 32;
  localparam int unsigned MODE_BIT_BCAST1  = 22;
  localparam int unsigned MODE_BIT_BCAST9  = 23;
  localparam int unsigned MODE_BIT_DUAL    = 21;

  // Instruction groups handled by the block.
  typedef enum logic [1:0] {
    OP_NONE     = 2'h0,
    OP_IDX_MOVE = 2'h1,
    OP_REG_MOVE = 2'h3,
    OP_SHIFT    = 2'h2
  } op_e;

  // Access width of a memory move.
  typedef enum logic [1:0] {
    WIDTH_NORMAL = 2'h0,
    WIDTH_SHORT  = 2'h1,
    WIDTH_LONG   = 2'h2
  } width_e;

  // Execution phase of one instruction.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_ACCESS = 2'h1,
    ST_WRITE  = 2'h3
  } state_e;

endpackage

// *** src/element_addr_gen.sv ***
`timescale 1ns/1ps

// Forms the two element addresses and the updated index for one memory move.
module element_addr_gen (
  // Operands
  input  wire logic [dual_move_pkg::ADDR_W-1:0] index_val,
  input  wire logic [dual_move_pkg::ADDR_W-1:0] modify_val,
  input  wire logic                             pre_modify,
  input  wire logic                             broadcast,
  input  wire dual_move_pkg::width_e            width,
  // Results
  output      logic [dual_move_pkg::ADDR_W-1:0] first_addr,
  output      logic [dual_move_pkg::ADDR_W-1:0] second_addr,
  output      logic [dual_move_pkg::ADDR_W-1:0] index_next
);

  logic [dual_move_pkg::ADDR_W-1:0] offset;
  logic [dual_move_pkg::ADDR_W-1:0] second_base;

  always_comb begin
    // Long words keep the normal-word step; broadcast takes no offset, else the offset follows the word size.
    if (broadcast) begin
      offset = dual_move_pkg::OFFSET_NONE;
    end else if (width == dual_move_pkg::WIDTH_SHORT) begin
      offset = dual_move_pkg::OFFSET_SHORT;
    end else begin
      offset = dual_move_pkg::OFFSET_NORMAL;
    end
    second_base = index_val + offset;
    index_next  = index_val + modify_val;
    if (pre_modify) begin
      first_addr  = index_val + modify_val;
      second_addr = second_base + modify_val;
    end else begin
      first_addr  = index_val;
      second_addr = second_base;
    end
  end

endmodule

// *** bench/simd_dual_element_data_move_asserts.sv ***
`timescale 1ns/1ps

module simd_dual_element_data_move_asserts (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // Instruction
  input  wire logic               instr_valid,
  input  wire dual_move_pkg::op_e instr_op,
  input  wire logic               cond_first,
  input  wire logic               cond_second,
  input  wire logic               mem_read,
  input  wire logic               mem_enable,
  input  wire logic               long_word_option,
  input  wire logic               short_word_access,
  input  wire logic [7:0]         imm_field,
  input  wire logic [3:0]         index_sel,
  input  wire logic [31:0]        primary_mode_control_word,
  // Outputs
  input  wire logic               busy,
  input  wire logic               first_mem_req,
  input  wire logic               second_mem_req,
  input  wire logic               mem_long,
  input  wire logic [31:0]        first_addr,
  input  wire logic [31:0]        second_addr,
  input  wire logic [7:0]         shift_operand
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic take, go, dual, both, plain, shrt;
  assign take = instr_valid && !busy;
  assign go = take && mem_enable
              && (instr_op == dual_move_pkg::OP_IDX_MOVE || instr_op == dual_move_pkg::OP_SHIFT);
  assign dual = primary_mode_control_word[21];
  assign both = go && dual && cond_first && cond_second;
  assign plain = index_sel != 4'h1 && index_sel != 4'h9;
  assign shrt = short_word_access && !long_word_option;

  property p_req_taken; go && cond_first |=> first_mem_req; endproperty
  a_req_taken: assert property (p_req_taken) else $error("no first request");
  property p_req_gated; go && !cond_first |=> !first_mem_req; endproperty
  a_req_gated: assert property (p_req_gated) else $error("gated request");
  property p_own_cond; go && dual && cond_second |=> second_mem_req; endproperty
  a_own_cond: assert property (p_own_cond) else $error("no second request");
  property p_single; second_mem_req |-> $past(dual); endproperty
  a_single: assert property (p_single) else $error("second request in single mode");
  property p_off_one; both && plain && !shrt |=> second_addr == first_addr + 32'h1; endproperty
  a_off_one: assert property (p_off_one) else $error("offset one wrong");
  property p_off_two; both && plain && shrt |=> second_addr == first_addr + 32'h2; endproperty
  a_off_two: assert property (p_off_two) else $error("offset two wrong");
  property p_bcast;
    both && mem_read && index_sel == 4'h1 && primary_mode_control_word[22]
      |=> second_addr == first_addr;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast offset wrong");
  property p_long; go && cond_first && long_word_option |=> mem_long; endproperty
  a_long: assert property (p_long) else $error("long access missing");
  property p_shift;
    take && instr_op == dual_move_pkg::OP_SHIFT |=> shift_operand == $past(imm_field);
  endproperty
  a_shift: assert property (p_shift) else $error("shift operand wrong");

  c_bcast: cover property (both && index_sel == 4'h9 && primary_mode_control_word[23]);
  c_move: cover property (take && instr_op == dual_move_pkg::OP_REG_MOVE && dual);
  c_shift: cover property (both && instr_op == dual_move_pkg::OP_SHIFT);
endmodule

bind simd_dual_element_data_move
  simd_dual_element_data_move_asserts simd_dual_element_data_move_asserts_inst (.*);

// *** bench/mem_partner.sv ***
`timescale 1ns/1ps

// Answers each element's request one cycle later; otherwise the data flips every cycle.
module mem_partner (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Requests
  input  wire logic        first_mem_req,
  input  wire logic        second_mem_req,
  input  wire logic [31:0] first_addr,
  input  wire logic [31:0] second_addr,
  // Read data
  output      logic [31:0] first_rd_data,
  output      logic [31:0] second_rd_data
);
  function automatic logic [31:0] fetch(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction

  // A stale sample would see inverted data, so late capture cannot pass.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      first_rd_data  <= 32'h0;
      second_rd_data <= 32'h0;
    end else begin
      first_rd_data  <= first_mem_req ? fetch(first_addr) : ~first_rd_data;
      second_rd_data <= second_mem_req ? fetch(second_addr) : ~second_rd_data;
    end
  end
endmodule

// *** bench/tb_simd_dual_element_data_move.sv ***
`timescale 1ns/1ps

module tb_simd_dual_element_data_move;
  logic               sys_clk, reset, instr_valid, cond_first, cond_second, is_swap;
  logic               mem_read, mem_enable, pre_modify, use_imm_modify, long_word_option;
  logic               short_word_access, split_operand, comp_present, busy, first_mem_req;
  logic               second_mem_req, mem_we, mem_long, mem_short, first_comp_en;
  logic               second_comp_en, shift_split;
  dual_move_pkg::op_e instr_op, op;
  logic [7:0]         imm_field, shift_operand;
  logic [3:0]         index_sel, modify_sel, src_sel, dst_sel;
  logic [31:0]        primary_mode_control_word, first_rd_data, second_rd_data, r;
  logic [31:0]        first_comp_result, second_comp_result, first_addr, second_addr;
  logic [31:0]        first_wr_data, second_wr_data, first_reg_view, second_reg_view;
  logic [31:0]        index_view, fa, sa, md;
  logic [31:0]        ix [16], fx [16], sx [16];
  logic               d, bc;
  int                 miscompares, tests_run;

  simd_dual_element_data_move simd_dual_element_data_move_inst (.*);
  mem_partner mem_partner_inst (.*);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] word(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Returns at the falling edge just after the taking edge, while the pulses still stand.
  task automatic issue(input dual_move_pkg::op_e o);
    instr_op = o;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(25 * 2000);
    miscompares++;
    summarize();
  end

  initial begin
    {instr_valid, cond_first, cond_second, is_swap, mem_read, mem_enable, pre_modify} = '0;
    {use_imm_modify, long_word_option, short_word_access, split_operand, comp_present} = '0;
    {imm_field, index_sel, modify_sel, src_sel, dst_sel} = '0;
    {primary_mode_control_word, first_comp_result, second_comp_result} = '0;
    instr_op = dual_move_pkg::OP_NONE;
    for (int j = 0; j < 16; j++) begin
      ix[j] = 32'h0;
      fx[j] = 32'h0;
      sx[j] = 32'h0;
    end
    r = 32'hac7f;
    reset = 1'b1;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    for (int i = 0; i < 40; i++) begin
      r = nx(r);
      d = r[0];
      {mem_enable, comp_present} = 2'h3;
      mem_read = r[27];
      cond_first = r[3:1] != 3'h0;
      cond_second = r[5:4] != 2'h0;
      pre_modify = r[6] | !cond_first;
      use_imm_modify = r[7];
      long_word_option = r[8];
      short_word_access = r[9];
      imm_field = r[17:10];
      split_operand = r[18];
      index_sel = (i % 4 == 0) ? (i[2] ? 4'h9 : 4'h1) : r[22:19];
      dst_sel = r[26:23];
      primary_mode_control_word = {8'h0, r[29:28] & {2{d}}, d, 21'h0};
      first_comp_result = nx(r);
      second_comp_result = ~r;
      op = r[30] ? dual_move_pkg::OP_SHIFT : dual_move_pkg::OP_IDX_MOVE;
      if (r[30]) begin
        pre_modify = 1'b0;
        use_imm_modify = 1'b0;
        cond_first = 1'b1;
      end
      md = use_imm_modify ? {{24{imm_field[7]}}, imm_field} : 32'h0;
      bc = d && mem_read && ((index_sel == 4'h1 && r[28]) || (index_sel == 4'h9 && r[29]));
      fa = pre_modify ? ix[index_sel] + md : ix[index_sel];
      sa = fa + (bc ? 32'h0 : (short_word_access && !long_word_option) ? 32'h2 : 32'h1);
      issue(op);
      chk("first_mem_req", {31'h0, cond_first}, {31'h0, first_mem_req});
      chk("second_mem_req", {31'h0, d & cond_second}, {31'h0, second_mem_req});
      chk("second_comp_en", {31'h0, d & cond_second}, {31'h0, second_comp_en});
      if (cond_first) chk("first_addr", fa, first_addr);
      if (cond_first) chk("mem_long", {31'h0, long_word_option}, {31'h0, mem_long});
      if (d && cond_second) chk("second_addr", sa, second_addr);
      if (r[30]) chk("shift_operand", {24'h0, imm_field}, {24'h0, shift_operand});
      if (r[30]) chk("shift_split", {31'h0, split_operand}, {31'h0, shift_split});
      chk("busy", {31'h0, cond_first | (d & cond_second)}, {31'h0, busy});
      chk("first_comp_en", {31'h0, cond_first}, {31'h0, first_comp_en});
      if (cond_first) chk("mem_short", {31'h0, r[9] & ~r[8]}, {31'h0, mem_short});
      if (cond_first) chk("mem_we", {31'h0, !mem_read}, {31'h0, mem_we});
      if (cond_first && !mem_read) chk("first_wr_data", fx[0], first_wr_data);
      if (d && cond_second && !mem_read) chk("second_wr_data", sx[0], second_wr_data);
      if (cond_first) fx[dst_sel] = mem_read ? word(fa) : first_comp_result;
      if (d && cond_second) sx[dst_sel] = mem_read ? word(sa) : second_comp_result;
      if (!pre_modify) ix[index_sel] = ix[index_sel] + md;
      repeat (2) @(negedge sys_clk);
      chk("first_reg_view", fx[dst_sel], first_reg_view);
      chk("second_reg_view", sx[dst_sel], second_reg_view);
      if (!pre_modify) chk("index_view", ix[index_sel], index_view);
    end
    for (int i = 0; i < 16; i++) begin
      r = nx(r);
      d = r[0];
      cond_first = r[3:1] != 3'h0;
      cond_second = r[5:4] != 2'h0;
      is_swap = r[6];
      comp_present = r[15];
      first_comp_result = ~r;
      second_comp_result = nx(~r);
      src_sel = r[10:7];
      dst_sel = is_swap ? src_sel : r[14:11];
      primary_mode_control_word = {10'h0, d, 21'h0};
      if (is_swap && cond_first) begin
        fa = fx[dst_sel];
        fx[dst_sel] = sx[src_sel];
        sx[src_sel] = fa;
      end else if (!is_swap && cond_first && (!d || cond_second)) begin
        fx[dst_sel] = fx[src_sel];
        if (d) sx[dst_sel] = sx[src_sel];
      end
      if (comp_present && cond_first) fx[dst_sel] = first_comp_result;
      if (comp_present && d && cond_second) sx[dst_sel] = second_comp_result;
      issue(dual_move_pkg::OP_REG_MOVE);
      chk("second_comp_en", {31'h0, comp_present & d & cond_second}, {31'h0, second_comp_en});
      @(negedge sys_clk);
      chk("first_reg_view", fx[dst_sel], first_reg_view);
      chk("second_reg_view", sx[dst_sel], second_reg_view);
    end
    summarize();
  end
endmodule
